// [eds_pkg.sv]
// Functional notes
// - a rising run line initialises every axis
// - a falling run line stops all axes at once, flushing pending edges
// - ready output copies the synchronised run line
// - trigger edges are dispatch requests only while the axes run
// - dispatch table holds 32 rows, one per edge polarity per trigger, one field per axis
// - each field is empty or holds a step number 0 to 255
// - normal trigger edge starts a sequence on each fitted axis with a valid field
// - acknowledge output toggles whenever run or any trigger changes
// - default status outputs depend on axis count
// - user-controlled status outputs follow only set and clear commands from sequences
// - selected-axis trigger uses only the field of the selected axis
// - axis select is binary: input 17 msb, input 16 middle, cpu input 1 lsb
// - command-only trigger still looks up the row for valid step numbers
// - command-only trigger issues the step command, running sequences continue
// - every discrete input and output has its own polarity invert bit
package eds_pkg;
  // sizes
  localparam int unsigned EDS_NUM_IN    = 16;
  localparam int unsigned EDS_MAX_AX    = 8;
  localparam int unsigned EDS_ROWS      = 32;
  localparam int unsigned EDS_PIN_W     = 20;
  localparam int unsigned EDS_OUT_INV_W = 10;
  localparam int unsigned EDS_IRQ_W     = 4;
  // positions in the synchronised pin vector
  localparam int unsigned EDS_PIN_SEL1  = 16;
  localparam int unsigned EDS_PIN_SEL2  = 17;
  localparam int unsigned EDS_PIN_RUN   = 18;
  localparam int unsigned EDS_PIN_SEL0  = 19;
  // output invert positions
  localparam int unsigned EDS_OINV_RDY  = 8;
  localparam int unsigned EDS_OINV_ACK  = 9;
  // table entry layout
  localparam int unsigned EDS_ENT_VALID = 8;
  // interrupt bits
  localparam int unsigned EDS_IRQ_RISE  = 0;
  localparam int unsigned EDS_IRQ_FALL  = 1;
  localparam int unsigned EDS_IRQ_DISP  = 2;
  localparam int unsigned EDS_IRQ_DROP  = 3;
  // register byte offsets
  localparam logic [10:0] EDS_OFS_SINGLE  = 11'h000;
  localparam logic [10:0] EDS_OFS_CMDONLY = 11'h004;
  localparam logic [10:0] EDS_OFS_USEROUT = 11'h008;
  localparam logic [10:0] EDS_OFS_INV_IN  = 11'h00C;
  localparam logic [10:0] EDS_OFS_INV_OUT = 11'h010;
  localparam logic [10:0] EDS_OFS_STATE   = 11'h014;
  localparam logic [10:0] EDS_OFS_IRQ_ST  = 11'h018;
  localparam logic [10:0] EDS_OFS_IRQ_MSK = 11'h01C;
  localparam logic [10:0] EDS_OFS_TABLE   = 11'h400;
  // reset values
  localparam logic [15:0] EDS_RST_MASK16  = 16'h0000;
  localparam logic [7:0]  EDS_RST_MASK8   = 8'h00;
  localparam logic [19:0] EDS_RST_INV_IN  = 20'h00000;
  localparam logic [9:0]  EDS_RST_INV_OUT = 10'h000;
  localparam logic [8:0]  EDS_RST_ENTRY   = 9'h000;
  localparam logic [3:0]  EDS_RST_IRQ     = 4'h0;
  // run state of the axes
  typedef enum logic [0:0] {
    EDS_ST_STOP = 1'b0,
    EDS_ST_RUN  = 1'b1
  } eds_run_e;
endpackage

// [eds_edge_if.sv]
`timescale 1ns/1ns
// synchronised levels and edges of the discrete pins
interface eds_edge_if #(parameter int unsigned W = 20);
  logic [W-1:0] level;
  logic [W-1:0] rise;
  logic [W-1:0] fall;
  modport src (output level, output rise, output fall);
  modport dst (input level, input rise, input fall);
endinterface

// [eds_sync_edge.sv]
`timescale 1ns/1ns
module eds_sync_edge
  import eds_pkg::*;
#(
  parameter int unsigned W = 20
) (
  input  wire logic         i_clk,   // system clock
  input  wire logic         i_rst_b, // sync reset, active low
  input  wire logic         i_ce,    // clock enable
  input  wire logic [W-1:0] i_pins,  // raw pins
  input  wire logic [W-1:0] i_inv,   // per-pin invert
  eds_edge_if.src           o_edges  // levels and edges
);
  logic [W-1:0] s1_q;
  logic [W-1:0] s2_q;
  logic [W-1:0] prev_q;
  logic [W-1:0] lvl;

  // two-flop synchroniser
  always_ff @(posedge i_clk) begin
    if (!i_rst_b) begin
      s1_q <= '0;
      s2_q <= '0;
    end else if (i_ce) begin
      s1_q <= i_pins;
      s2_q <= s1_q;
    end
  end

  // polarity applied after the second flop
  assign lvl = s2_q ^ i_inv;

  // previous sample for edge compare
  always_ff @(posedge i_clk) begin
    if (!i_rst_b) begin
      prev_q <= '0;
    end else if (i_ce) begin
      prev_q <= lvl;
    end
  end

  // edges from consecutive samples, valid only while enabled
  assign o_edges.level = lvl;
  assign o_edges.rise  = i_ce ? (lvl & ~prev_q) : '0;
  assign o_edges.fall  = i_ce ? (~lvl & prev_q) : '0;
endmodule

// [eds_dispatch.sv]
`timescale 1ns/1ns
module eds_dispatch
  import eds_pkg::*;
#(
  parameter int unsigned NUM_AXES = 4
) (
  input  wire logic        i_clk,             // system clock
  input  wire logic        i_rst_b,           // sync reset, active low
  input  wire logic        i_ce,              // clock enable
  input  wire logic        i_run,             // run line pin
  input  wire logic [15:0] i_trig,            // trigger pins
  input  wire logic        i_axsel_msb,       // axis select msb pin
  input  wire logic        i_axsel_mid,       // axis select middle pin
  input  wire logic        i_axsel_lsb,       // axis select lsb pin
  input  wire logic [7:0]  i_axis_in_pos,     // per-axis target reached
  input  wire logic [7:0]  i_axis_halt,       // per-axis halt fault
  input  wire logic [7:0]  i_user_set,        // set user outputs
  input  wire logic [7:0]  i_user_clr,        // clear user outputs
  input  wire logic [10:0] i_avs_address,     // byte address
  input  wire logic        i_avs_read,        // read request
  input  wire logic        i_avs_write,       // write request
  input  wire logic [31:0] i_avs_writedata,   // write data
  input  wire logic [3:0]  i_avs_byteenable,  // byte lanes
  output logic      [31:0] o_avs_readdata,    // read data
  output logic             o_avs_waitrequest, // stall
  output logic             o_ready,           // ready pin
  output logic             o_ack,             // acknowledge pin
  output logic      [7:0]  o_status,          // status pins
  output logic      [7:0]  o_axis_init,       // init pulse per axis
  output logic      [7:0]  o_axis_stop,       // stop pulse per axis
  output logic      [7:0]  o_seq_start,       // start sequence pulse
  output logic      [7:0]  o_cmd_issue,       // command-only pulse
  output logic      [63:0] o_step,            // step number per axis
  output logic      [4:0]  o_disp_row,        // dispatched row
  output logic             o_irq              // interrupt, active high
);
  localparam logic [7:0] AX_MASK = 8'((1 << NUM_AXES) - 1);

  // refuse axis counts the status map cannot serve
  generate
    if (NUM_AXES < 2 || NUM_AXES > EDS_MAX_AX) begin : g_bad_axes
      $error("eds_dispatch: NUM_AXES must be 2 to 8");
    end
  endgenerate

  // byte-lane merge of a register word
  function automatic logic [31:0] be_merge(input logic [31:0] old,
                                           input logic [31:0] nw,
                                           input logic [3:0]  be);
    logic [31:0] r;
    r = old;
    for (int b = 0; b < 4; b++) begin
      if (be[b]) begin
        r[b*8 +: 8] = nw[b*8 +: 8];
      end
    end
    return r;
  endfunction

  // lowest set bit; bit 5 flags a hit
  function automatic logic [5:0] first_one(input logic [31:0] v);
    logic [5:0] r;
    r = 6'h00;
    for (int k = 31; k >= 0; k--) begin
      if (v[k]) begin
        r = {1'b1, 5'(k)};
      end
    end
    return r;
  endfunction

  logic [15:0]  single_q;
  logic [15:0]  cmdonly_q;
  logic [7:0]   userout_q;
  logic [19:0]  inv_in_q;
  logic [9:0]   inv_out_q;
  logic [3:0]   irq_st_q;
  logic [3:0]   irq_msk_q;
  logic [8:0]   tab_q [0:255];
  logic         rsp_q;
  logic [31:0]  rdata_q;
  logic [31:0]  rd_d;
  eds_run_e     run_st_q;
  logic [31:0]  pend_q;
  logic [31:0]  new_pend;
  logic [5:0]   pick;
  logic         found;
  logic [7:0]   hit;
  logic [63:0]  step_d;
  logic         ack_q;
  logic         ack_d;
  logic [7:0]   user_q;
  logic [7:0]   def_stat;
  logic [7:0]   stat_d;
  logic [3:0]   ev;
  logic [2:0]   axsel;
  logic         run_lvl;
  logic         run_rise;
  logic         run_fall;
  logic         gate;
  logic         dropped;
  logic         req;
  logic         wr_acc;
  logic [10:0]  reg_addr;
  logic [7:0]   tab_idx;

  // pin synchroniser and edge detector
  eds_edge_if #(.W(EDS_PIN_W)) pins_if ();
  eds_sync_edge #(.W(EDS_PIN_W)) u_sync (
    .i_clk   (i_clk),
    .i_rst_b (i_rst_b),
    .i_ce    (i_ce),
    .i_pins  ({i_axsel_lsb, i_run, i_axsel_msb, i_axsel_mid, i_trig}),
    .i_inv   (inv_in_q),
    .o_edges (pins_if.src)
  );

  // run line and axis select from the synchronised pins
  assign run_lvl  = pins_if.level[EDS_PIN_RUN];
  assign run_rise = pins_if.rise[EDS_PIN_RUN];
  assign run_fall = pins_if.fall[EDS_PIN_RUN];
  assign axsel    = {pins_if.level[EDS_PIN_SEL2],
                     pins_if.level[EDS_PIN_SEL1],
                     pins_if.level[EDS_PIN_SEL0]};

  // bus handshake: one wait cycle, then the access completes
  assign req               = i_avs_read | i_avs_write;
  assign o_avs_waitrequest = req & ~rsp_q;
  assign wr_acc            = i_avs_write & rsp_q & i_ce;
  assign reg_addr          = {i_avs_address[10:2], 2'b00};
  assign tab_idx           = i_avs_address[9:2];
  assign o_avs_readdata    = rdata_q;

  always_ff @(posedge i_clk) begin
    if (!i_rst_b) begin
      rsp_q <= 1'b0;
    end else if (i_ce) begin
      rsp_q <= req & ~rsp_q;
    end
  end

  // read mux, unmapped reads as zero
  always_comb begin
    rd_d = 32'h0;
    if (i_avs_address[10]) begin
      rd_d = {23'h0, tab_q[tab_idx]};
    end else begin
      case (reg_addr)
        EDS_OFS_SINGLE:  rd_d = {16'h0, single_q};
        EDS_OFS_CMDONLY: rd_d = {16'h0, cmdonly_q};
        EDS_OFS_USEROUT: rd_d = {24'h0, userout_q};
        EDS_OFS_INV_IN:  rd_d = {12'h0, inv_in_q};
        EDS_OFS_INV_OUT: rd_d = {22'h0, inv_out_q};
        EDS_OFS_STATE:   rd_d = {13'h0, axsel, stat_d, 6'h0, run_st_q, run_lvl};
        EDS_OFS_IRQ_ST:  rd_d = {28'h0, irq_st_q};
        EDS_OFS_IRQ_MSK: rd_d = {28'h0, irq_msk_q};
        default:         rd_d = 32'h0;
      endcase
    end
  end

  // read data captured for the completing cycle
  always_ff @(posedge i_clk) begin
    if (!i_rst_b) begin
      rdata_q <= 32'h0;
    end else if (i_ce && i_avs_read && !rsp_q) begin
      rdata_q <= rd_d;
    end
  end

  // mode and polarity configuration registers
  always_ff @(posedge i_clk) begin
    if (!i_rst_b) begin
      single_q  <= EDS_RST_MASK16;
      cmdonly_q <= EDS_RST_MASK16;
      userout_q <= EDS_RST_MASK8;
      inv_in_q  <= EDS_RST_INV_IN;
      inv_out_q <= EDS_RST_INV_OUT;
      irq_msk_q <= EDS_RST_IRQ;
    end else if (wr_acc && !i_avs_address[10]) begin
      case (reg_addr)
        EDS_OFS_SINGLE:  single_q  <= 16'(be_merge({16'h0, single_q}, i_avs_writedata,
                                                   i_avs_byteenable));
        EDS_OFS_CMDONLY: cmdonly_q <= 16'(be_merge({16'h0, cmdonly_q}, i_avs_writedata,
                                                   i_avs_byteenable));
        EDS_OFS_USEROUT: userout_q <= 8'(be_merge({24'h0, userout_q}, i_avs_writedata,
                                                  i_avs_byteenable));
        EDS_OFS_INV_IN:  inv_in_q  <= 20'(be_merge({12'h0, inv_in_q}, i_avs_writedata,
                                                   i_avs_byteenable));
        EDS_OFS_INV_OUT: inv_out_q <= 10'(be_merge({22'h0, inv_out_q}, i_avs_writedata,
                                                   i_avs_byteenable));
        EDS_OFS_IRQ_MSK: irq_msk_q <= 4'(be_merge({28'h0, irq_msk_q}, i_avs_writedata,
                                                  i_avs_byteenable));
        default: begin
        end
      endcase
    end
  end

  // dispatch table: 32 rows by 8 axis fields, valid bit plus step
  always_ff @(posedge i_clk) begin
    if (!i_rst_b) begin
      for (int e = 0; e < 256; e++) begin
        tab_q[e] <= EDS_RST_ENTRY;
      end
    end else if (wr_acc && i_avs_address[10]) begin
      if (i_avs_byteenable[0]) begin
        tab_q[tab_idx][7:0] <= i_avs_writedata[7:0];
      end
      if (i_avs_byteenable[1]) begin
        tab_q[tab_idx][EDS_ENT_VALID] <= i_avs_writedata[EDS_ENT_VALID];
      end
    end
  end

  // run state: start on rise, stop on fall
  always_ff @(posedge i_clk) begin
    if (!i_rst_b) begin
      run_st_q <= EDS_ST_STOP;
    end else if (i_ce) begin
      case (run_st_q)
        EDS_ST_STOP: if (run_rise) run_st_q <= EDS_ST_RUN;
        EDS_ST_RUN:  if (run_fall) run_st_q <= EDS_ST_STOP;
        default:     run_st_q <= EDS_ST_STOP;
      endcase
    end
  end

  // init and stop pulses to all fitted axes
  always_ff @(posedge i_clk) begin
    if (!i_rst_b) begin
      o_axis_init <= 8'h00;
      o_axis_stop <= 8'h00;
    end else if (i_ce) begin
      o_axis_init <= run_rise ? AX_MASK : 8'h00;
      o_axis_stop <= run_fall ? AX_MASK : 8'h00;
    end
  end

  // trigger edges become pending rows only while running
  assign gate = (run_st_q == EDS_ST_RUN) & ~run_fall;
  always_comb begin
    new_pend = 32'h0;
    for (int i = 0; i < EDS_NUM_IN; i++) begin
      new_pend[2*i]     = pins_if.rise[i] & gate;
      new_pend[2*i + 1] = pins_if.fall[i] & gate;
    end
  end
  assign dropped = (|(pins_if.rise[15:0] | pins_if.fall[15:0])) & ~gate;

  // lowest pending row is served first
  assign pick  = first_one(pend_q);
  assign found = pick[5] & ~run_fall & i_ce;

  // pending rows: new edges win over the served clear, stop flushes all
  always_ff @(posedge i_clk) begin
    if (!i_rst_b) begin
      pend_q <= 32'h0;
    end else if (i_ce) begin
      if (run_fall) begin
        pend_q <= 32'h0;
      end else begin
        pend_q <= (pend_q & ~(found ? (32'h1 << pick[4:0]) : 32'h0)) | new_pend;
      end
    end
  end

  // per-axis field lookup of the picked row
  always_comb begin
    hit    = 8'h00;
    step_d = 64'h0;
    for (int a = 0; a < NUM_AXES; a++) begin
      step_d[a*8 +: 8] = tab_q[{pick[4:0], 3'(a)}][7:0];
      hit[a] = tab_q[{pick[4:0], 3'(a)}][EDS_ENT_VALID]
               & (~single_q[pick[4:1]] | (axsel == 3'(a)));
    end
  end

  // dispatch outputs: sequence start or command-only
  always_ff @(posedge i_clk) begin
    if (!i_rst_b) begin
      o_seq_start <= 8'h00;
      o_cmd_issue <= 8'h00;
      o_step      <= 64'h0;
      o_disp_row  <= 5'h00;
    end else if (i_ce) begin
      o_seq_start <= (found && !cmdonly_q[pick[4:1]]) ? hit : 8'h00;
      o_cmd_issue <= (found && cmdonly_q[pick[4:1]]) ? hit : 8'h00;
      if (found) begin
        o_step     <= step_d;
        o_disp_row <= pick[4:0];
      end
    end
  end

  // acknowledge toggles on any run or trigger change
  assign ack_d = ack_q ^ (|(pins_if.rise[15:0] | pins_if.fall[15:0]) | run_rise | run_fall);
  always_ff @(posedge i_clk) begin
    if (!i_rst_b) begin
      ack_q <= 1'b0;
      o_ack <= 1'b0;
    end else if (i_ce) begin
      ack_q <= ack_d;
      o_ack <= ack_d ^ inv_out_q[EDS_OINV_ACK];
    end
  end

  // ready copies the run line
  always_ff @(posedge i_clk) begin
    if (!i_rst_b) begin
      o_ready <= 1'b0;
    end else if (i_ce) begin
      o_ready <= run_lvl ^ inv_out_q[EDS_OINV_RDY];
    end
  end

  // user output bits, set wins over clear
  always_ff @(posedge i_clk) begin
    if (!i_rst_b) begin
      user_q <= 8'h00;
    end else if (i_ce) begin
      user_q <= (user_q & ~i_user_clr) | i_user_set;
    end
  end

  // default status map by axis count, user bits override
  assign def_stat = (NUM_AXES <= 4) ? {i_axis_halt[3:0], i_axis_in_pos[3:0]}
                                    : i_axis_in_pos;
  assign stat_d   = (userout_q & user_q) | (~userout_q & def_stat);

  always_ff @(posedge i_clk) begin
    if (!i_rst_b) begin
      o_status <= 8'h00;
    end else if (i_ce) begin
      o_status <= stat_d ^ inv_out_q[7:0];
    end
  end

  // sticky interrupt status, write one to clear, events win
  assign ev = {dropped, found, run_fall, run_rise};
  always_ff @(posedge i_clk) begin
    if (!i_rst_b) begin
      irq_st_q <= EDS_RST_IRQ;
    end else if (i_ce) begin
      if (wr_acc && reg_addr == EDS_OFS_IRQ_ST && !i_avs_address[10] && i_avs_byteenable[0]) begin
        irq_st_q <= (irq_st_q & ~i_avs_writedata[3:0]) | ev;
      end else begin
        irq_st_q <= irq_st_q | ev;
      end
    end
  end

  // level interrupt from unmasked status
  always_ff @(posedge i_clk) begin
    if (!i_rst_b) begin
      o_irq <= 1'b0;
    end else if (i_ce) begin
      o_irq <= |(irq_st_q & irq_msk_q);
    end
  end
endmodule

// [eds_dispatch_sva.sv]
`timescale 1ns/1ns
module eds_dispatch_sva #(
  parameter int unsigned NUM_AXES = 4
) (
  input wire logic        i_clk,             // system clock
  input wire logic        i_rst_b,           // sync reset
  input wire logic        i_run,             // run pin
  input wire logic [15:0] i_trig,            // trigger pins
  input wire logic        i_avs_read,        // bus read
  input wire logic        i_avs_write,       // bus write
  input wire logic        o_avs_waitrequest, // bus stall
  input wire logic        o_ready,           // ready pin
  input wire logic        o_ack,             // ack pin
  input wire logic [7:0]  o_axis_init,       // init pulses
  input wire logic [7:0]  o_axis_stop,       // stop pulses
  input wire logic [7:0]  o_seq_start,       // start pulses
  input wire logic [7:0]  o_cmd_issue        // command pulses
);
  logic [7:0] fit;
  logic [2:0] age_q;
  // mask of fitted axes
  assign fit = 8'((16'h1 << NUM_AXES) - 16'h1);
  // edges since reset, so pin history is never read from before the synchroniser cleared
  always_ff @(posedge i_clk) begin
    if (!i_rst_b)
      age_q <= 3'h0;
    else if (age_q != 3'h7)
      age_q <= age_q + 3'h1;
  end
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_rst_b);
  property p_ready;
    age_q == 3'h7 |-> o_ready == $past(i_run, 3);
  endproperty
  a_ready: assert property (p_ready) else $error("ready does not follow run");
  property p_ack;
    age_q == 3'h7 |-> $changed(o_ack) ==
      ($past({i_run, i_trig}, 3) != $past({i_run, i_trig}, 4));
  endproperty
  a_ack: assert property (p_ack) else $error("ack toggle mismatch");
  property p_init;
    $rose(o_ready) |-> o_axis_init == fit;
  endproperty
  a_init: assert property (p_init) else $error("axes not initialised");
  property p_init_cause;
    o_axis_init != 8'h00 |-> $rose(o_ready);
  endproperty
  a_init_cause: assert property (p_init_cause) else $error("init without run rise");
  property p_stop;
    $fell(o_ready) |-> o_axis_stop == fit;
  endproperty
  a_stop: assert property (p_stop) else $error("axes not stopped");
  property p_gate;
    (o_seq_start | o_cmd_issue) != 8'h00 |-> o_ready || $past(o_ready);
  endproperty
  a_gate: assert property (p_gate) else $error("dispatch while stopped");
  property p_fit;
    ((o_seq_start | o_cmd_issue) & ~fit) == 8'h00;
  endproperty
  a_fit: assert property (p_fit) else $error("dispatch to unfitted axis");
  property p_excl;
    (o_seq_start & o_cmd_issue) == 8'h00;
  endproperty
  a_excl: assert property (p_excl) else $error("start and command together");
  property p_wait;
    $rose(i_avs_read || i_avs_write) |-> o_avs_waitrequest ##1 !o_avs_waitrequest;
  endproperty
  a_wait: assert property (p_wait) else $error("bus answer not after one cycle");
endmodule
bind eds_dispatch eds_dispatch_sva #(.NUM_AXES(NUM_AXES)) u_sva (
  .i_clk(i_clk), .i_rst_b(i_rst_b), .i_run(i_run), .i_trig(i_trig),
  .i_avs_read(i_avs_read), .i_avs_write(i_avs_write),
  .o_avs_waitrequest(o_avs_waitrequest), .o_ready(o_ready), .o_ack(o_ack),
  .o_axis_init(o_axis_init), .o_axis_stop(o_axis_stop),
  .o_seq_start(o_seq_start), .o_cmd_issue(o_cmd_issue)
);

// [eds_panel.sv]
`timescale 1ns/1ns
module eds_panel (
  input  wire logic        i_clk,  // system clock
  output logic             o_run,  // run line
  output logic      [15:0] o_trig, // trigger pins
  output logic      [2:0]  o_axsel // axis select code
);
  // switches all open at power up
  initial begin
    o_run = 1'b0;
    o_trig = 16'h0000;
    o_axsel = 3'h0;
  end
  // set run and triggers just after an edge, hold for gap cycles
  task automatic drive(input logic r, input logic [15:0] t, input int gap);
    @(posedge i_clk);
    o_run <= r;
    o_trig <= t;
    repeat (gap) @(posedge i_clk);
  endtask
  // binary axis code, bit 2 on the msb pin
  task automatic select(input logic [2:0] a, input int gap);
    @(posedge i_clk);
    o_axsel <= a;
    repeat (gap) @(posedge i_clk);
  endtask
endmodule

// [tb_edge_to_sequence_dispatch.sv]
`timescale 1ns/1ns
module tb_edge_to_sequence_dispatch;
  import eds_pkg::*;
  localparam int unsigned NAX = 4;
  logic        clk = 1'b0;
  logic        rst_b = 1'b0;
  logic [7:0]  in_pos = 8'h00;
  logic [7:0]  halt = 8'h00;
  logic [7:0]  user_set = 8'h00;
  logic [7:0]  user_clr = 8'h00;
  logic [10:0] addr = 11'h000;
  logic        rd = 1'b0;
  logic        wr = 1'b0;
  logic [31:0] wdata = 32'h0000_0000;
  logic [3:0]  be = 4'hF;
  logic        run, waitreq, ready, ack, irq;
  logic [15:0] trig;
  logic [2:0]  axsel;
  logic [31:0] rdata;
  logic [7:0]  status, init, stop, start, cmd;
  logic [63:0] step, last_step;
  logic [4:0]  row;
  logic [7:0]  init_seen = 8'h00;
  logic [7:0]  stop_seen = 8'h00;
  logic [84:0] log_q[$];
  int          fail_count = 0;
  int          n_checks = 0;
  // 20 MHz clock
  always #25 clk = ~clk;
  eds_panel u_panel (.i_clk(clk), .o_run(run), .o_trig(trig), .o_axsel(axsel));
  eds_dispatch #(.NUM_AXES(NAX)) u_dut (
    .i_clk(clk), .i_rst_b(rst_b), .i_ce(1'b1), .i_run(run), .i_trig(trig),
    .i_axsel_msb(axsel[2]), .i_axsel_mid(axsel[1]), .i_axsel_lsb(axsel[0]),
    .i_axis_in_pos(in_pos), .i_axis_halt(halt), .i_user_set(user_set),
    .i_user_clr(user_clr), .i_avs_address(addr), .i_avs_read(rd), .i_avs_write(wr),
    .i_avs_writedata(wdata), .i_avs_byteenable(be), .o_avs_readdata(rdata),
    .o_avs_waitrequest(waitreq), .o_ready(ready), .o_ack(ack), .o_status(status),
    .o_axis_init(init), .o_axis_stop(stop), .o_seq_start(start), .o_cmd_issue(cmd),
    .o_step(step), .o_disp_row(row), .o_irq(irq));
  // log each dispatch and latch the last init and stop masks
  always @(posedge clk) begin
    if ((start | cmd) != 8'h00)
      log_q.push_back({row, start, cmd, step});
    if (init != 8'h00)
      init_seen <= init;
    if (stop != 8'h00)
      stop_seen <= stop;
  end
  task automatic chk(input logic [63:0] got, input logic [63:0] exp);
    n_checks++;
    if (got !== exp) begin
      fail_count++;
      $display("[FAIL] t=%0t got=%0h exp=%0h", $time, got, exp);
    end
  endtask
  task automatic close_out();
    $display("checks=%0d mismatches=%0d", n_checks, fail_count);
    if (fail_count == 0 && n_checks > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  task automatic wt(input int n);
    repeat (n) @(posedge clk);
  endtask
  // one bus access, held until waitrequest is seen low
  task automatic bus(input logic w, input logic [10:0] a, input logic [31:0] d,
                     input logic [3:0] b, output logic [31:0] q);
    int n;
    n = 0;
    @(posedge clk);
    addr <= a;
    wdata <= d;
    be <= b;
    rd <= !w;
    wr <= w;
    do begin
      @(posedge clk);
      n++;
    end while (waitreq !== 1'b0 && n < 40);
    q = rdata;
    chk(64'(n < 40), 64'h1);
    rd <= 1'b0;
    wr <= 1'b0;
  endtask
  task automatic wr32(input logic [10:0] a, input logic [31:0] d);
    logic [31:0] q;
    bus(1'b1, a, d, 4'hF, q);
  endtask
  task automatic rd_chk(input logic [10:0] a, input logic [31:0] e);
    logic [31:0] q;
    bus(1'b0, a, 32'h0, 4'hF, q);
    chk(q, e);
  endtask
  function automatic logic [10:0] ta(input int r, input int a);
    return EDS_OFS_TABLE + 11'(4 * (r * 8 + a));
  endfunction
  task automatic ent(input int r, input int a, input logic [7:0] s);
    wr32(ta(r, a), {23'h0, 1'b1, s});
  endtask
  // pop the oldest dispatch and compare row, start and command masks
  task automatic disp(input logic [4:0] r, input logic [7:0] s, input logic [7:0] c);
    logic [84:0] e;
    e = '1;
    if (log_q.size() != 0)
      e = log_q.pop_front();
    last_step = e[63:0];
    chk(64'(e[84:64]), 64'({r, s, c}));
  endtask
  // reset values, unmapped and read-only places, byte lanes of a table entry
  task automatic t_regs();
    logic [31:0] q;
    for (int i = 0; i < 8; i++)
      rd_chk(11'(4 * i), 32'h0);
    rd_chk(ta(31, 7), 32'h0);
    wr32(11'h300, 32'hFFFF_FFFF);
    rd_chk(11'h300, 32'h0);
    wr32(EDS_OFS_STATE, 32'hFFFF_FFFF);
    rd_chk(EDS_OFS_STATE, 32'h0);
    bus(1'b1, ta(0, 0), 32'h0000_01AB, 4'h1, q);
    rd_chk(ta(0, 0), 32'h0000_00AB);
  endtask
  // run rise: ready, init of fitted axes, ack, interrupt raise and clear
  task automatic t_run_up();
    logic a0;
    a0 = ack;
    wr32(EDS_OFS_IRQ_MSK, 32'h1);
    u_panel.drive(1'b1, 16'h0000, 8);
    chk(ready, 1);
    chk(init_seen, 8'h0F);
    chk(ack, !a0);
    chk(irq, 1);
    rd_chk(EDS_OFS_IRQ_ST, 32'h1);
    wr32(EDS_OFS_IRQ_ST, 32'h1);
    wt(2);
    chk(irq, 0);
  endtask
  // both polarities of trigger 0, step 0 and 255, an entry on an unfitted axis
  task automatic t_normal();
    logic a0;
    ent(0, 0, 8'h05);
    ent(0, 2, 8'hFF);
    ent(0, 5, 8'h77);
    ent(1, 1, 8'h00);
    log_q.delete();
    a0 = ack;
    u_panel.drive(1'b1, 16'h0001, 8);
    chk(ack, !a0);
    disp(5'd0, 8'h05, 8'h00);
    chk({last_step[23:16], last_step[7:0]}, 16'hFF05);
    u_panel.drive(1'b1, 16'h0000, 8);
    disp(5'd1, 8'h02, 8'h00);
    chk(last_step[15:8], 8'h00);
    chk(log_q.size(), 0);
    chk(irq, 0);
  endtask
  // two triggers rising together are served lowest first
  task automatic t_simul();
    ent(4, 0, 8'h11);
    ent(6, 1, 8'h22);
    u_panel.drive(1'b1, 16'h000C, 8);
    disp(5'd4, 8'h01, 8'h00);
    chk(last_step[7:0], 8'h11);
    disp(5'd6, 8'h02, 8'h00);
    u_panel.drive(1'b1, 16'h0000, 8);
  endtask
  // single-axis trigger 7 under every axis code
  task automatic t_single();
    wr32(EDS_OFS_SINGLE, 32'h0080);
    for (int a = 0; a < 4; a++)
      ent(14, a, 8'h40 + 8'(a));
    for (int a = 0; a < 8; a++) begin
      u_panel.select(3'(a), 3);
      log_q.delete();
      u_panel.drive(1'b1, 16'h0080, 8);
      if (a < NAX) begin
        disp(5'd14, 8'(1 << a), 8'h00);
        chk(last_step[a*8+:8], 8'h40 + 8'(a));
      end
      chk(log_q.size(), 0);
      u_panel.drive(1'b1, 16'h0000, 8);
    end
  endtask
  // command-only trigger 9 issues the step command and starts nothing
  task automatic t_cmd();
    wr32(EDS_OFS_CMDONLY, 32'h0200);
    ent(18, 1, 8'h33);
    log_q.delete();
    u_panel.drive(1'b1, 16'h0200, 8);
    disp(5'd18, 8'h00, 8'h02);
    chk(last_step[15:8], 8'h33);
    u_panel.drive(1'b1, 16'h0000, 8);
  endtask
  // default status map, a user-controlled bit, output inversion
  task automatic t_status();
    @(posedge clk);
    in_pos <= 8'hA4;
    halt <= 8'h3C;
    wt(3);
    chk(status, 8'hC4);
    wr32(EDS_OFS_USEROUT, 32'h1);
    in_pos <= 8'hA4;
    user_set <= 8'h01;
    user_clr <= 8'h01;
    @(posedge clk);
    user_set <= 8'h00;
    user_clr <= 8'h00;
    wt(3);
    chk(status, 8'hC5);
    user_clr <= 8'h01;
    in_pos <= 8'hA5;
    @(posedge clk);
    user_clr <= 8'h00;
    wt(3);
    chk(status, 8'hC4);
    wr32(EDS_OFS_INV_OUT, 32'h00FF);
    wt(3);
    chk(status, 8'h3B);
    wr32(EDS_OFS_INV_OUT, 32'h0);
    wr32(EDS_OFS_USEROUT, 32'h0);
  endtask
  // run falls with a trigger edge, then triggers while stopped, then a prompt restart
  task automatic t_stop();
    ent(2, 0, 8'h09);
    log_q.delete();
    u_panel.drive(1'b0, 16'h0002, 8);
    chk(ready, 0);
    chk(stop_seen, 8'h0F);
    chk(log_q.size(), 0);
    rd_chk(EDS_OFS_IRQ_ST, 32'hE);
    u_panel.drive(1'b0, 16'h0000, 8);
    chk(log_q.size(), 0);
    init_seen = 8'h00;
    u_panel.drive(1'b1, 16'h0000, 3);
    u_panel.drive(1'b1, 16'h0002, 8);
    chk(init_seen, 8'h0F);
    disp(5'd2, 8'h01, 8'h00);
  endtask
  initial begin
    wt(5);
    rst_b <= 1'b1;
    wt(2);
    t_regs();
    t_run_up();
    t_normal();
    t_simul();
    t_single();
    t_cmd();
    t_status();
    t_stop();
    close_out();
  end
  // hang guard, far beyond the few hundred cycles the scenarios need
  initial begin
    wt(20000);
    fail_count++;
    close_out();
  end
endmodule
